// *** src/fswd_decode.sv ***
// Purpose: turn sequencer word fields into registered control strobes
// Assumes: seq_word is valid from the prom for the current prom_addr
// Notes: clk runs four phases per sequencer instruction
`timescale 1ns/1ps
module fswd_decode
  import fswd_pkg::*;
(
  input wire logic clk, // sequencer phase clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic [WORD_W-1:0] seq_word, // word from sequencer prom
  input wire logic [PAGE_W-1:0] page_sel, // requested page, asynchronous
  input wire logic host_req_async, // backend request from host card
  input wire logic snapshot_output_enable_n, // from clear memory
  input wire logic accum_clear_flag, // from clear memory
  input wire logic final_result_flag, // from result memory
  output logic [PAGE_W+PC_W-1:0] prom_addr, // page and step
  output logic dram_we_n_02, // write enable, pair 02
  output logic dram_we_n_46, // write enable, pair 46
  output logic dram_we_n_13, // write enable, pair 13
  output logic dram_we_n_57, // write enable, pair 57
  output logic dram_we_n_out, // write enable, output buffer
  output logic [CAS_W-1:0] cas_n, // column strobes 0,1,4,5,8
  output logic backend_fifo_write_clock, // backend fifo data clock
  output logic backend_final_result_enable, // fifo write allowed
  output logic [BE_CNT_W-1:0] be_result_count, // backend read counter
  output logic [MAIN_CNT_W-1:0] main_result_count, // main loop counter
  output logic [ASEL_W-1:0] dram_addr_mux_sel, // 8 to 1 address mux
  output logic xbar_a_en_n, // crossbar a bus enable
  output logic xbar_b_en_n, // crossbar b bus enable
  output logic accum_clear, // clear accumulator
  output logic [TAP_W-1:0] tap_weight_select, // tap weight index
  output logic main_loop_tick, // registered tick bit
  output logic handshake_start, // one-cycle backend start
  output logic handshake_grant // backend transfer in progress
);

  typedef struct packed {
    logic [1:0] ph;
    logic [PC_W-1:0] pc;
    logic [PAGE_W-1:0] page;
    logic [PAGE_W-1:0] page_s1;
    logic [PAGE_W-1:0] page_s2;
    logic req_s1;
    logic req_s2;
    logic we02_n;
    logic we46_n;
    logic we13_n;
    logic we57_n;
    logic weout_n;
    logic [CAS_W-1:0] precas_n;
    logic [CAS_W-1:0] cas_n;
    logic dlyrc;
    logic fifo_clk;
    logic fin_en;
    logic [BE_CNT_W-1:0] be_cnt;
    logic [MAIN_CNT_W-1:0] main_cnt;
    logic [ASEL_W-1:0] asel;
    logic aenb_n;
    logic benb_n;
    logic clr;
    logic [TAP_W-1:0] tap;
    logic tick;
    logic [2:0] run;
    logic start;
    logic busy;
  } fswd_state_t;

  fswd_state_t s_reg;
  fswd_state_t s_next;
  logic boundary;
  logic start_ok;

  assign boundary = (s_reg.ph == PH_LAST);
  // a request may begin only with tick low and no count run pending
  assign start_ok = !s_reg.tick && (s_reg.run == 3'h0);

  always_comb begin
    s_next = s_reg;
    s_next.ph = s_reg.ph + 2'h1;
    s_next.page_s1 = page_sel;
    s_next.page_s2 = s_reg.page_s1;
    s_next.req_s1 = host_req_async;
    s_next.req_s2 = s_reg.req_s1;
    s_next.fin_en = !final_result_flag;
    s_next.start = 1'b0;
    if (boundary) begin
      // new instruction takes effect; fields from this word, pairs 13 and 57 from the last
      if (s_reg.pc[3:0] == SECTION_END && s_reg.page_s2 != s_reg.page) begin
        // page switch only between sections keeps sections whole
        s_next.page = s_reg.page_s2;
        s_next.pc = '0;
      end else begin
        s_next.pc = s_reg.pc + 8'h01;
      end
      s_next.we02_n = seq_word[BIT_WE0_N];
      s_next.we46_n = seq_word[BIT_WE4_N];
      s_next.we13_n = s_reg.we02_n;
      s_next.we57_n = s_reg.we46_n;
      s_next.precas_n = seq_word[BIT_PRECAS_LO +: CAS_W];
      s_next.dlyrc = seq_word[BIT_DLYRC];
      s_next.asel = seq_word[BIT_ASEL_LO +: ASEL_W];
      s_next.aenb_n = seq_word[BIT_AENB_N];
      s_next.benb_n = seq_word[BIT_BENB_N];
      s_next.clr = seq_word[BIT_ACCUM_CLEAR_FLAG_EN] && accum_clear_flag;
      s_next.tap = seq_word[BIT_TAP_LO +: TAP_W];
      s_next.tick = seq_word[BIT_TICK];
      if (seq_word[BIT_RCNTENBL]) begin
        s_next.be_cnt = s_reg.be_cnt + 11'h001;
        s_next.run = (s_reg.run == RCNT_RUN_LAST) ? 3'h0 :
          s_reg.run + 3'h1;
      end else begin
        s_next.run = 3'h0;
      end
      if (seq_word[BIT_RESCNT]) begin
        s_next.main_cnt = s_reg.main_cnt + 8'h01;
      end
    end
    s_next.weout_n = snapshot_output_enable_n;
    // strobes off in the last phase: three of four phases active
    if (s_next.ph == PH_LAST) begin
      s_next.cas_n = {CAS_W{1'b1}};
      s_next.fifo_clk = 1'b0;
    end else begin
      s_next.cas_n = s_next.precas_n;
      s_next.fifo_clk = s_next.dlyrc && s_reg.fin_en &&
        (s_next.asel == ASEL_BACKEND);
    end
    if (s_reg.busy) begin
      s_next.busy = s_reg.req_s2;
    end else if (s_reg.req_s2 && start_ok) begin
      s_next.busy = 1'b1;
      s_next.start = 1'b1;
    end
  end

  // every decoded output leaves from this register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_reg <= '0;
      s_reg.page <= PAGE_MISC;
      s_reg.we02_n <= 1'b1;
      s_reg.we46_n <= 1'b1;
      s_reg.we13_n <= 1'b1;
      s_reg.we57_n <= 1'b1;
      s_reg.weout_n <= 1'b1;
      s_reg.precas_n <= {CAS_W{1'b1}};
      s_reg.cas_n <= {CAS_W{1'b1}};
      s_reg.aenb_n <= 1'b1;
      s_reg.benb_n <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign prom_addr = {s_reg.page, s_reg.pc};
  assign dram_we_n_02 = s_reg.we02_n;
  assign dram_we_n_46 = s_reg.we46_n;
  assign dram_we_n_13 = s_reg.we13_n;
  assign dram_we_n_57 = s_reg.we57_n;
  assign dram_we_n_out = s_reg.weout_n;
  assign cas_n = s_reg.cas_n;
  assign backend_fifo_write_clock = s_reg.fifo_clk;
  assign backend_final_result_enable = s_reg.fin_en;
  assign be_result_count = s_reg.be_cnt;
  assign main_result_count = s_reg.main_cnt;
  assign dram_addr_mux_sel = s_reg.asel;
  assign xbar_a_en_n = s_reg.aenb_n;
  assign xbar_b_en_n = s_reg.benb_n;
  assign accum_clear = s_reg.clr;
  assign tap_weight_select = s_reg.tap;
  assign main_loop_tick = s_reg.tick;
  assign handshake_start = s_reg.start;
  assign handshake_grant = s_reg.busy;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  cas_off_phase_a: assert property (
    s_reg.ph == PH_LAST |-> &s_reg.cas_n)
    else $error("cas active in the off phase");

  pair13_delay_a: assert property (
    boundary |=> s_reg.we13_n == $past(s_reg.we02_n))
    else $error("pair 13 write enable not one cycle late");

  pair57_delay_a: assert property (
    boundary |=> s_reg.we57_n == $past(s_reg.we46_n))
    else $error("pair 57 write enable not one cycle late");

  fifo_clk_gate_a: assert property (
    s_reg.fifo_clk |-> $past(s_reg.fin_en) && s_reg.dlyrc &&
      s_reg.ph != PH_LAST)
    else $error("fifo clock without enable");

  fifo_be_addr_a: assert property (
    s_reg.fifo_clk |-> s_reg.asel == ASEL_BACKEND)
    else $error("fifo clock outside backend address cycle");

  start_tick_a: assert property (
    s_reg.start |-> $past(!s_reg.tick && s_reg.run == 3'h0))
    else $error("backend start while tick or count run");

  clear_gate_a: assert property (
    boundary |=> s_reg.clr == $past(seq_word[BIT_ACCUM_CLEAR_FLAG_EN] &&
      accum_clear_flag))
    else $error("accumulator clear not gated by both flags");

  be_count_step_a: assert property (
    boundary && seq_word[BIT_RCNTENBL] |=>
      s_reg.be_cnt == $past(s_reg.be_cnt) + 11'h001)
    else $error("backend result counter did not advance");

  instr_span_a: assert property (
    boundary |=> !boundary [*3] ##1 boundary)
    else $error("instruction does not span four phases");

  pc_hold_a: assert property (
    !boundary |=> $stable(s_reg.pc))
    else $error("step changed inside an instruction");

  // field loads: each field equals the word taken one clk earlier
  asel_load_a: assert property (
    boundary |=> s_reg.asel == $past(seq_word[BIT_ASEL_LO +: ASEL_W]))
    else $error("address select not taken from the word");

  we_direct_a: assert property (
    boundary |=> s_reg.we02_n == $past(seq_word[BIT_WE0_N]) &&
      s_reg.we46_n == $past(seq_word[BIT_WE4_N]))
    else $error("pair 02 or 46 write enable not from the word");

  // first clk after reset still shows the reset copy, so skip it
  weout_copy_a: assert property (
    $past(rst_n) |-> s_reg.weout_n == $past(snapshot_output_enable_n))
    else $error("output buffer write enable not a copy");

  final_enable_a: assert property (
    $past(rst_n) |-> s_reg.fin_en == !$past(final_result_flag))
    else $error("final enable does not follow the flag");

  tick_load_a: assert property (
    boundary |=> s_reg.tick == $past(seq_word[BIT_TICK]))
    else $error("tick not taken from the word");

  run_block_a: assert property (
    s_reg.run != 3'h0 |=> !s_reg.start)
    else $error("backend start inside a count run");

  tap_load_a: assert property (
    boundary |=> s_reg.tap == $past(seq_word[BIT_TAP_LO +: TAP_W]))
    else $error("tap select not taken from the word");

  xbar_load_a: assert property (
    boundary |=> s_reg.aenb_n == $past(seq_word[BIT_AENB_N]) &&
      s_reg.benb_n == $past(seq_word[BIT_BENB_N]))
    else $error("crossbar enables not taken from the word");

  main_count_step_a: assert property (
    boundary && seq_word[BIT_RESCNT] |=>
      s_reg.main_cnt == $past(s_reg.main_cnt) + 8'h01)
    else $error("main loop result counter did not advance");

  page_at_end_a: assert property (
    $changed(s_reg.page) |-> $past(boundary) && s_reg.pc == '0 &&
      $past(s_reg.pc[3:0]) == SECTION_END)
    else $error("page changed away from a section end");

  field_hold_a: assert property (
    !boundary |=> $stable(s_reg.asel) && $stable(s_reg.tap) &&
      $stable(s_reg.we02_n) && $stable(s_reg.clr))
    else $error("decoded field changed inside an instruction");

  be_count_hold_a: assert property (
    !(boundary && seq_word[BIT_RCNTENBL]) |=> $stable(s_reg.be_cnt))
    else $error("backend result counter moved without enable");

  fifo_write_c: cover property (s_reg.fifo_clk);
  handshake_c: cover property (s_reg.start ##[1:20] !s_reg.busy);
  clear_c: cover property (s_reg.clr);
  page_switch_c: cover property ($changed(s_reg.page));
  tick_hold_c: cover property (s_reg.tick && s_reg.req_s2 && !s_reg.busy);

endmodule

// *** src/fswd_pkg.sv ***
// Purpose: constants for the filter sequencer word decoder
// Assumes: one 103-bit sequencer word presented per instruction
// Notes: bit positions not fixed elsewhere are chosen here
package fswd_pkg;
  localparam int WORD_W = 103;
  // instruction word field positions
  localparam int BIT_TAP_LO = 0;
  localparam int TAP_W = 3;
  localparam int BIT_ACCUM_CLEAR_FLAG_EN = 3;
  localparam int BIT_ASEL_LO = 8;
  localparam int ASEL_W = 3;
  localparam int BIT_AENB_N = 11;
  localparam int BIT_BENB_N = 12;
  localparam int BIT_WE0_N = 13;
  localparam int BIT_WE4_N = 14;
  localparam int BIT_PRECAS_LO = 15;
  localparam int CAS_W = 5;
  localparam int BIT_RESCNT = 57;
  localparam int BIT_RCNTENBL = 69;
  localparam int BIT_TICK = 70;
  localparam int BIT_DLYRC = 71;
  // address mux code that puts backend addresses on the dram bus
  localparam logic [2:0] ASEL_BACKEND = 3'h5;
  // one instruction spans four clk phases; cas held off in the last
  localparam logic [1:0] PH_LAST = 2'h3;
  localparam int SECTION_US = 2;
  localparam int INSTRS_PER_SECTION = 16;
  localparam logic [3:0] SECTION_END = 4'(INSTRS_PER_SECTION - 1);
  localparam logic [2:0] RCNT_RUN_LAST = 3'h6; // run of seven
  localparam int BE_CNT_W = 11;
  localparam int MAIN_CNT_W = 8;
  localparam int PC_W = 8;
  localparam int PAGE_W = 2;
  // program pages
  localparam logic [1:0] PAGE_MISC = 2'h0;
  localparam logic [1:0] PAGE_MAIN = 2'h1;
  localparam logic [1:0] PAGE_VAL_NORM = 2'h2;
  localparam logic [1:0] PAGE_VAL_RAW = 2'h3;
endpackage

// *** sim/fswd_far_model.sv ***
// Purpose: far side of the decoder: result memory and host card
// Assumes: the host raises its request just after a clk edge
// Notes: the final flag lags the read counter by one clk
`timescale 1ns/1ps
module fswd_far_model
  import fswd_pkg::*;
#(parameter int RESULTS_WANTED = 40)
(
  input wire logic clk, // phase clock
  input wire logic rst_n, // synchronous reset
  input wire logic want_xfer, // bench asks for one transfer
  input wire logic handshake_grant, // device grant
  input wire logic [BE_CNT_W-1:0] be_result_count, // backend read counter
  output logic host_req_async = 1'b0, // host request level
  output logic final_result_flag = 1'b0 // all results read
);
  always @(posedge clk) begin
    final_result_flag <= #1 rst_n &&
      be_result_count >= RESULTS_WANTED;
    // request held until granted, never dropped early
    if (!rst_n || handshake_grant)
      host_req_async <= #1 1'b0;
    else if (want_xfer)
      host_req_async <= #1 1'b1;
  end
endmodule

// *** sim/tb_filter_sequencer_word_decode.sv ***
// Purpose: self-checking bench for the sequencer word decoder
// Assumes: a word is taken every fourth clk after reset
// Notes: random words, then tick and count-run holds on the host
`timescale 1ns/1ps
module tb_filter_sequencer_word_decode;
  import fswd_pkg::*;
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
  num_errors++; $display("unexpected %s exp %h got %h", n, e, g); end end
  localparam int WANT = 40;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [WORD_W-1:0] seq_word = '0;
  logic [PAGE_W-1:0] page_sel = PAGE_MISC;
  logic snapshot_output_enable_n = 1'b1;
  logic accum_clear_flag = 1'b0;
  logic want_xfer = 1'b0;
  logic host_req_async, final_result_flag;
  logic [PAGE_W+PC_W-1:0] prom_addr;
  logic dram_we_n_02, dram_we_n_46, dram_we_n_13, dram_we_n_57, dram_we_n_out;
  logic [CAS_W-1:0] cas_n;
  logic backend_fifo_write_clock, backend_final_result_enable;
  logic [BE_CNT_W-1:0] be_result_count;
  logic [MAIN_CNT_W-1:0] main_result_count;
  logic [ASEL_W-1:0] dram_addr_mux_sel;
  logic xbar_a_en_n, xbar_b_en_n, accum_clear, main_loop_tick;
  logic [TAP_W-1:0] tap_weight_select;
  logic handshake_start, handshake_grant;
  logic [WORD_W-1:0] cur = '0;
  logic [WORD_W-1:0] prv = '1;
  logic accum_clear_flag_cur = 1'b0;
  logic fifo_ref = 1'b0;
  logic [1:0] page_ref = PAGE_MISC;
  int num_errors = 0, comparisons = 0, cycles = 0, starts = 0;
  int be_ref = 0, main_ref = 0, pc_ref = 0, mode = 0;

  always #25 clk = ~clk;
  fswd_decode dut (.clk, .rst_n, .seq_word, .page_sel, .host_req_async,
    .snapshot_output_enable_n, .accum_clear_flag, .final_result_flag,
    .prom_addr, .dram_we_n_02, .dram_we_n_46, .dram_we_n_13, .dram_we_n_57,
    .dram_we_n_out, .cas_n, .backend_fifo_write_clock,
    .backend_final_result_enable, .be_result_count, .main_result_count,
    .dram_addr_mux_sel, .xbar_a_en_n, .xbar_b_en_n, .accum_clear,
    .tap_weight_select, .main_loop_tick, .handshake_start, .handshake_grant);
  fswd_far_model #(.RESULTS_WANTED(WANT)) host (.clk, .rst_n, .want_xfer,
    .handshake_grant, .be_result_count, .host_req_async, .final_result_flag);

  task final_report;
    if (num_errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (handshake_start === 1'b1) begin
      starts++;
      want_xfer <= 1'b0;
      `CHK("grant", 1'b1, handshake_grant)
    end
    if (cycles == 2000) begin
      num_errors++;
      final_report();
    end
  end

  // mode 1 holds tick high, 2 low, 3 builds a count-enable run
  task drive_next;
    cur = WORD_W'({$urandom(), $urandom(), $urandom(), $urandom()});
    if ($urandom() % 2 == 0)
      cur[BIT_ASEL_LO +: ASEL_W] = ASEL_BACKEND;
    if (mode != 0)
      cur[BIT_TICK] = (mode == 1);
    if (mode != 0)
      cur[BIT_RCNTENBL] = (mode == 3);
    seq_word = cur;
    accum_clear_flag_cur = 1'($urandom());
    accum_clear_flag = accum_clear_flag_cur;
    snapshot_output_enable_n = 1'($urandom());
  endtask

  task check_word;
    `CHK("we02", cur[BIT_WE0_N], dram_we_n_02)
    `CHK("we46", cur[BIT_WE4_N], dram_we_n_46)
    `CHK("we13", prv[BIT_WE0_N], dram_we_n_13)
    `CHK("we57", prv[BIT_WE4_N], dram_we_n_57)
    `CHK("asel", cur[BIT_ASEL_LO +: ASEL_W], dram_addr_mux_sel)
    `CHK("xbar", cur[BIT_BENB_N -: 2], {xbar_b_en_n, xbar_a_en_n})
    `CHK("tap", cur[BIT_TAP_LO +: TAP_W], tap_weight_select)
    `CHK("tick", cur[BIT_TICK], main_loop_tick)
    `CHK("clr", cur[BIT_ACCUM_CLEAR_FLAG_EN] & accum_clear_flag_cur, accum_clear)
    `CHK("cas", cur[BIT_PRECAS_LO +: CAS_W], cas_n)
    fifo_ref = cur[BIT_DLYRC] && be_ref < WANT &&
      cur[BIT_ASEL_LO +: ASEL_W] == ASEL_BACKEND;
    `CHK("fifo", fifo_ref, backend_fifo_write_clock)
    be_ref += cur[BIT_RCNTENBL];
    main_ref += cur[BIT_RESCNT];
    `CHK("becnt", BE_CNT_W'(be_ref), be_result_count)
    `CHK("maincnt", MAIN_CNT_W'(main_ref), main_result_count)
    pc_ref = (pc_ref + 1) % 256;
    if (prom_addr[PC_W +: PAGE_W] !== page_ref) begin
      `CHK("pgturn", 4'h0, 4'(pc_ref))
      page_ref = PAGE_MAIN;
      pc_ref = 0;
    end
    `CHK("addr", {page_ref, 8'(pc_ref)}, prom_addr)
    prv = cur;
  endtask

  task run(input int n);
    for (int k = 0; k < n; k++) begin
      @(posedge clk);
      #1;
      check_word();
      drive_next();
      repeat (2) @(posedge clk);
      #1;
      `CHK("cashold", prv[BIT_PRECAS_LO +: CAS_W], cas_n)
      @(posedge clk);
      #1;
      `CHK("casoff", {CAS_W{1'b1}}, cas_n)
      `CHK("fifooff", 1'b0, backend_fifo_write_clock)
      `CHK("weout", snapshot_output_enable_n, dram_we_n_out)
      `CHK("finen", be_ref < WANT, backend_final_result_enable)
    end
  endtask

  initial begin
    void'($urandom(50));
    repeat (3) @(posedge clk);
    #1;
    rst_n = 1'b1;
    `CHK("rstcas", {CAS_W{1'b1}}, cas_n)
    `CHK("rstcnt", {BE_CNT_W{1'b0}}, be_result_count)
    drive_next();
    repeat (3) @(posedge clk);
    run(120);
    page_sel = PAGE_MAIN;
    run(40);
    `CHK("page", PAGE_MAIN, page_ref)
    mode = 1;
    run(2);
    want_xfer = 1'b1;
    run(5);
    `CHK("tickhold", 0, starts)
    mode = 3;
    run(7);
    `CHK("runhold", 0, starts)
    mode = 2;
    run(6);
    `CHK("start", 1, starts)
    `CHK("grantoff", 1'b0, handshake_grant)
    final_report();
  end
endmodule
